// >>> common/icf_regs.svh
// register offsets, field positions, reset values and timing counts for the capture block
`ifndef ICF_REGS_SVH
`define ICF_REGS_SVH
`define ICF_ADDR_W          4
`define ICF_OFS_CTRL        4'h0
`define ICF_OFS_BUF         4'h1
`define ICF_OFS_STAT        4'h2
`define ICF_CTRL_RESET      16'h0000
`define ICF_BIT_STOP_IDLE   13
`define ICF_BIT_TBSEL       7
`define ICF_BIT_EPI_HI      6
`define ICF_BIT_EPI_LO      5
`define ICF_BIT_OVF         4
`define ICF_BIT_BNE         3
`define ICF_BIT_MODE_HI     2
`define ICF_BIT_MODE_LO     0
`define ICF_FIFO_DEPTH      3'h4
`define ICF_LAT_CYCLES      2
`define ICF_DIV4_LAST       4'h3
`define ICF_DIV16_LAST      4'hf
`endif

// >>> common/icf_pkg.sv
// types shared by the capture block
package icf_pkg;
  typedef enum logic [2:0] {
    MODE_OFF     = 3'b000,
    MODE_BOTH    = 3'b001,
    MODE_FALL    = 3'b010,
    MODE_RISE    = 3'b011,
    MODE_DIV4    = 3'b100,
    MODE_DIV16   = 3'b101,
    MODE_UNUSED  = 3'b110,
    MODE_WAKE    = 3'b111
  } icf_mode_type;

  typedef struct packed {
    logic       stopInIdle;
    logic       timeBaseSel;
    logic [1:0] eventsPerIrqSel;
    logic [2:0] captureModeSel;
  } icf_ctrl_type;

  typedef struct packed {
    logic        valid;
    logic [15:0] value;
  } icf_sample_type;
endpackage

// >>> hdl/icf_edge_detect.sv
// synchroniser, edge detector and two-cycle event delay for the capture pin
module icf_edge_detect (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic arst_n,
  // pin and edges
  input  wire logic pinIn,
  output logic      riseEdge,
  output logic      fallEdge
);
  logic syncA;
  logic syncB;
  logic lastLevel;
  logic [1:0] riseDly;
  logic [1:0] fallDly;

  // =========================================
  // two-flop synchroniser; only syncB is looked at
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      syncA     <= 1'b0;
      syncB     <= 1'b0;
      lastLevel <= 1'b0;
    end
    else
    begin
      syncA     <= pinIn;
      syncB     <= syncA;
      lastLevel <= syncB;
    end
  end

  // =========================================
  // pad the event latency by two more cycles, giving four cycles after the pin transition against the documented two
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      riseDly <= 2'h0;
      fallDly <= 2'h0;
    end
    else
    begin
      riseDly <= {riseDly[0], syncB & ~lastLevel};
      fallDly <= {fallDly[0], ~syncB & lastLevel};
    end
  end

  assign riseEdge = riseDly[1];
  assign fallEdge = fallDly[1];
endmodule // icf_edge_detect

// >>> hdl/input_capture_fifo_irq.sv
// input capture channel: edge qualification, four-entry fifo, status, irq and dma request
//
// Chosen here: strobed register access and the address map.
`include "icf_regs.svh"

// What this block does
// - capture selected time base into four-entry fifo
// - status flags clear on reset or disable
// - not-empty flag set until fifo drained
// - read returns oldest, remaining entries move forward
// - fifth capture while full sets overflow
// - full fifo drops new capture values
// - fourth read after overflow clears flag
// - every-event or both-edge modes never overflow-flag
// - irq every one to four events
// - both-edge mode interrupts on every event
// - overflow inhibits irq unless every-event
// - event four cycles after pin transition
// - one dma request per capture event
// - sleep stops capture; wake mode rising irq
// - stop-in-idle picks idle behaviour
// - select bit one picks time base a
// - mode field selects edge qualification
module input_capture_fifo_irq (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  // register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic [15:0]      regRdata,
  // capture pin and time bases
  input  wire logic        capture_input_pin,
  input  wire logic [15:0] time_base_a,
  input  wire logic [15:0] time_base_b,
  // power state and interrupt enable
  input  wire logic        sleepMode,
  input  wire logic        idleMode,
  input  wire logic        capture_irq_enable,
  // event outputs
  output logic             capture_irq_flag,
  output logic             dmaRequest
);
  icf_pkg::icf_ctrl_type ctrl;
  logic [15:0] fifoMem [0:3];
  logic [2:0]  fillCount;
  logic        capture_overflow_flag;
  logic        overflowLatch;
  logic [1:0]  readsAfterOvf;
  logic [3:0]  prescale;
  logic [1:0]  eventCount;
  logic        riseEdge;
  logic        fallEdge;
  logic        halted;
  logic        disabled;
  logic        qualEdge;
  logic        captureEvent;
  logic        wakeEvent;
  logic        everyEvent;
  logic        bufRead;
  logic        fifoFull;
  logic [15:0] sampleValue;
  logic        irqEvent;

  // =========================================
  // pin conditioning
  icf_edge_detect u_edge (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .pinIn    (capture_input_pin),
    .riseEdge (riseEdge),
    .fallEdge (fallEdge)
  );

  // disabled means off or unused encoding
  function automatic logic is_off(input logic [2:0] m);
    is_off = (m == icf_pkg::MODE_OFF) || (m == icf_pkg::MODE_UNUSED);
  endfunction

  // =========================================
  // event qualification
  assign disabled = is_off(ctrl.captureModeSel);
  assign halted   = sleepMode || (idleMode && ctrl.stopInIdle);
  assign fifoFull = (fillCount == `ICF_FIFO_DEPTH);
  assign bufRead  = regRead && (regAddr == `ICF_OFS_BUF);

  // the prescaler counts only rising edges in the divide modes
  always_comb
  begin
    qualEdge = 1'b0;
    case (ctrl.captureModeSel)
      icf_pkg::MODE_BOTH:  qualEdge = riseEdge | fallEdge;
      icf_pkg::MODE_FALL:  qualEdge = fallEdge;
      icf_pkg::MODE_RISE:  qualEdge = riseEdge;
      icf_pkg::MODE_DIV4:  qualEdge = riseEdge && (prescale == `ICF_DIV4_LAST);
      icf_pkg::MODE_DIV16: qualEdge = riseEdge && (prescale == `ICF_DIV16_LAST);
      default:             qualEdge = 1'b0;
    endcase
  end

  assign captureEvent = qualEdge && !halted;
  assign wakeEvent    = (ctrl.captureModeSel == icf_pkg::MODE_WAKE) && halted
                        && riseEdge && capture_irq_enable;
  assign everyEvent   = (ctrl.eventsPerIrqSel == 2'h0)
                        || (ctrl.captureModeSel == icf_pkg::MODE_BOTH);
  assign sampleValue  = ctrl.timeBaseSel ? time_base_a : time_base_b;

  // =========================================
  // control word: status bits are read-only; mode change is software's duty
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      ctrl <= '0;
    else if (regWrite && (regAddr == `ICF_OFS_CTRL))
    begin
      ctrl.stopInIdle      <= regWdata[`ICF_BIT_STOP_IDLE];
      ctrl.timeBaseSel     <= regWdata[`ICF_BIT_TBSEL];
      ctrl.eventsPerIrqSel <= regWdata[`ICF_BIT_EPI_HI:`ICF_BIT_EPI_LO];
      ctrl.captureModeSel  <= regWdata[`ICF_BIT_MODE_HI:`ICF_BIT_MODE_LO];
    end
  end

  // =========================================
  // rising-edge prescaler, reset while disabled
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      prescale <= 4'h0;
    else if (disabled)
      prescale <= 4'h0;
    else if (riseEdge && !halted)
    begin
      if ((ctrl.captureModeSel == icf_pkg::MODE_DIV4) && (prescale == `ICF_DIV4_LAST))
        prescale <= 4'h0;
      else
        prescale <= prescale + 4'h1;
    end
  end

  // =========================================
  // fifo: shift-out on read keeps the oldest entry at slot 0
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fillCount  <= 3'h0;
      fifoMem[0] <= 16'h0000;
      fifoMem[1] <= 16'h0000;
      fifoMem[2] <= 16'h0000;
      fifoMem[3] <= 16'h0000;
    end
    else if (disabled)
      fillCount <= 3'h0;
    else
    begin
      if (bufRead && fillCount != 3'h0)
      begin
        fifoMem[0] <= fifoMem[1];
        fifoMem[1] <= fifoMem[2];
        fifoMem[2] <= fifoMem[3];
      end
      // a full fifo keeps its four values; a same-cycle read frees a slot
      if (captureEvent && (!fifoFull || bufRead))
      begin
        if (bufRead && fillCount != 3'h0)
        begin
          fifoMem[fillCount[1:0] - 2'h1] <= sampleValue;
          fillCount <= fillCount;
        end
        else
        begin
          fifoMem[fillCount[1:0]] <= sampleValue;
          fillCount <= fillCount + 3'h1;
        end
      end
      else if (bufRead && fillCount != 3'h0)
        fillCount <= fillCount - 3'h1;
    end
  end

  // =========================================
  // overflow flag and its four-read clear; set wins over clear
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      capture_overflow_flag <= 1'b0;
      overflowLatch         <= 1'b0;
      readsAfterOvf         <= 2'h0;
    end
    else if (disabled)
    begin
      capture_overflow_flag <= 1'b0;
      overflowLatch         <= 1'b0;
      readsAfterOvf         <= 2'h0;
    end
    else if (captureEvent && fifoFull && !bufRead)
    begin
      overflowLatch <= 1'b1;
      readsAfterOvf <= 2'h0;
      capture_overflow_flag <= !everyEvent;
    end
    else if (overflowLatch && bufRead)
    begin
      readsAfterOvf <= readsAfterOvf + 2'h1;
      if (readsAfterOvf == 2'h3)
      begin
        capture_overflow_flag <= 1'b0;
        overflowLatch         <= 1'b0;
      end
    end
  end

  // =========================================
  // events-per-interrupt counter
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      eventCount <= 2'h0;
    else if (disabled)
      eventCount <= 2'h0;
    else if (captureEvent)
    begin
      if (eventCount == ctrl.eventsPerIrqSel)
        eventCount <= 2'h0;
      else
        eventCount <= eventCount + 2'h1;
    end
  end

  // overflow inhibits only the counted interrupt styles
  assign irqEvent = wakeEvent ||
                    (captureEvent && (everyEvent ||
                     ((eventCount == ctrl.eventsPerIrqSel) && !overflowLatch)));

  // =========================================
  // one-cycle event pulses
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      capture_irq_flag <= 1'b0;
      dmaRequest       <= 1'b0;
    end
    else
    begin
      capture_irq_flag <= irqEvent;
      dmaRequest       <= captureEvent;
    end
  end

  // =========================================
  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      regRdata <= 16'h0000;
    else if (regRead)
    begin
      case (regAddr)
        `ICF_OFS_CTRL:
        begin
          regRdata <= 16'h0000;
          regRdata[`ICF_BIT_STOP_IDLE] <= ctrl.stopInIdle;
          regRdata[`ICF_BIT_TBSEL]     <= ctrl.timeBaseSel;
          regRdata[`ICF_BIT_EPI_HI:`ICF_BIT_EPI_LO]   <= ctrl.eventsPerIrqSel;
          regRdata[`ICF_BIT_OVF]       <= capture_overflow_flag;
          regRdata[`ICF_BIT_BNE]       <= (fillCount != 3'h0);
          regRdata[`ICF_BIT_MODE_HI:`ICF_BIT_MODE_LO] <= ctrl.captureModeSel;
        end
        `ICF_OFS_BUF:  regRdata <= (fillCount != 3'h0) ? fifoMem[0] : 16'h0000;
        `ICF_OFS_STAT: regRdata <= {13'h0000, fillCount};
        default:       regRdata <= 16'h0000;
      endcase
    end
    else
      regRdata <= 16'h0000;
  end
endmodule // input_capture_fifo_irq

// >>> verification/icf_capture_sva.sv
// assertion checker watching the capture channel ports
module icf_capture_sva (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        arst_n,
  // register port
  input wire logic [3:0]  regAddr,
  input wire logic [15:0] regWdata,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [15:0] regRdata,
  // pin, power state and events
  input wire logic        capture_input_pin,
  input wire logic        sleepMode,
  input wire logic        capture_irq_flag,
  input wire logic        dmaRequest
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] ctrl;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  // shadow of the writable control bits; flag bits are left out since software cannot set them
  always_ff @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
      ctrl <= 16'h0000;
    else if (regWrite && regAddr == 4'h0)
      ctrl <= regWdata & 16'h20e7;
  // ==========
  // port relations
  rdata_idle_a: assert property (!$past(regRead) |-> regRdata == 16'h0000)
    else $error("read data not zero outside the read slot");
  ctrl_back_a: assert property (regRead && regAddr == 4'h0 |=> (regRdata & 16'h20e7) == ctrl)
    else $error("control word readback differs");
  both_no_ovf_a: assert property (regRead && regAddr == 4'h0 && ctrl[2:0] == 3'b001 |=> !regRdata[4])
    else $error("overflow flag set in both-edge mode");
  dma_cause_a: assert property (dmaRequest |-> $past(capture_input_pin, 2) != $past(capture_input_pin, 10))
    else $error("capture event without a recent pin edge");
  every_irq_a: assert property (dmaRequest && (ctrl[2:0] == 3'b001 || ctrl[6:5] == 2'b00) |-> capture_irq_flag)
    else $error("event without interrupt in every-event setting");
  irq_dma_a: assert property (capture_irq_flag && ctrl[2:0] != 3'b111 |-> dmaRequest)
    else $error("interrupt without a capture event");
  off_quiet_a: assert property ((ctrl[2:0] == 3'b000) [*6] |-> !dmaRequest && !capture_irq_flag)
    else $error("activity while disabled");
  wake_no_dma_a: assert property (ctrl[2:0] == 3'b111 |-> !dmaRequest)
    else $error("capture in wake-up mode");
  sleep_quiet_a: assert property (sleepMode [*8] |-> !dmaRequest)
    else $error("capture during sleep");
endmodule // icf_capture_sva

bind input_capture_fifo_irq icf_capture_sva u_sva (.ref_clk(ref_clk), .arst_n(arst_n),
  .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
  .regRdata(regRdata), .capture_input_pin(capture_input_pin), .sleepMode(sleepMode),
  .capture_irq_flag(capture_irq_flag), .dmaRequest(dmaRequest));

// >>> verification/icf_pin_source.sv
// behavioural signal source driving the capture pin
module icf_pin_source (
  // level requested by the test sequence
  input  wire logic level,
  // capture pin
  output wire logic pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // skewed off the clock so the synchroniser sees a truly async edge; one driver only
  assign #3 pin = level;
endmodule // icf_pin_source

// >>> verification/input_capture_fifo_irq_tb.sv
// self-checking bench for the capture channel
module input_capture_fifo_irq_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk, arst_n, regWrite, regRead, level, pin;
  logic        sleepMode, idleMode, irqEn, irqFlag, dmaReq;
  logic [3:0]  regAddr;
  logic [15:0] regWdata, regRdata, tbA, tbB;
  int          n_fail, n_checks, nIrq, nDma, b0;

  input_capture_fifo_irq dut (.ref_clk(ref_clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .capture_input_pin(pin), .time_base_a(tbA), .time_base_b(tbB), .sleepMode(sleepMode),
    .idleMode(idleMode), .capture_irq_enable(irqEn), .capture_irq_flag(irqFlag),
    .dmaRequest(dmaReq));
  icf_pin_source src (.level(level), .pin(pin));

  // ==========
  // clock and pulse counters
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    if (irqFlag === 1'b1) nIrq++;
    if (dmaReq === 1'b1) nDma++;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 chk(regRdata, exp);
  endtask
  // time bases held still until the delayed event has landed
  task automatic ev(input logic v, input logic [15:0] k);
    @(posedge ref_clk);
    tbA <= 16'ha000 | k;
    tbB <= 16'h5000 | k;
    level <= v;
    repeat (12) @(posedge ref_clk);
  endtask
  task automatic pulse(input logic [15:0] k);
    ev(1'b1, k);
    ev(1'b0, k);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ==========
  // test sequence
  initial
  begin
    {regWrite, regRead, level, sleepMode, idleMode, irqEn} = '0;
    regAddr = 4'h0;
    regWdata = 16'h0000;
    tbA = 16'h0000;
    tbB = 16'h0000;
    {n_fail, n_checks, nIrq, nDma} = '0;
    arst_n = 1'b0;
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(4'h0, 16'h0000);
    rd(4'h5, 16'h0000);
    // eight rising edges, irq every fourth, time base a, flag bits written in vain;
    // events five to eight overflow, so the second counted irq must be held off
    wr(4'h0, 16'h00fb);
    rd(4'h0, 16'h00e3);
    for (int k = 1; k <= 8; k++) pulse(16'(k));
    chk(16'(nIrq), 16'h0001);
    rd(4'h0, 16'h00fb);
    rd(4'h2, 16'h0004);
    for (int k = 1; k <= 4; k++) rd(4'h1, 16'ha000 | 16'(k));
    rd(4'h0, 16'h00e3);
    // falling edges only, time base b
    wr(4'h0, 16'h0000);
    wr(4'h0, 16'h0002);
    ev(1'b1, 16'h0011);
    rd(4'h2, 16'h0000);
    ev(1'b0, 16'h0012);
    rd(4'h1, 16'h5012);
    // both edges ignore the per-interrupt count and never flag overflow
    wr(4'h0, 16'h0000);
    wr(4'h0, 16'h0021);
    b0 = nIrq;
    for (int k = 1; k <= 5; k++) ev(k[0], 16'(k));
    chk(16'(nIrq - b0), 16'h0005);
    rd(4'h0, 16'h0029);
    wr(4'h0, 16'h0000);
    rd(4'h0, 16'h0000);
    rd(4'h2, 16'h0000);
    // pin back low while off, so the prescaler count starts from a clean rise
    b0 = nDma;
    ev(1'b0, 16'h0000);
    chk(16'(nDma - b0), 16'h0000);
    // prescaled modes: divide by 4, then by 16
    for (int m = 4; m <= 5; m++)
    begin
      wr(4'h0, 16'(m));
      b0 = nDma;
      repeat ((m == 4) ? 3 : 15) pulse(16'h0000);
      chk(16'(nDma - b0), 16'h0000);
      pulse(16'h0000);
      chk(16'(nDma - b0), 16'h0001);
      wr(4'h0, 16'h0000);
    end
    // idle with and without stop, then sleep
    wr(4'h0, 16'h2003);
    idleMode <= 1'b1;
    b0 = nDma;
    pulse(16'h0000);
    chk(16'(nDma - b0), 16'h0000);
    wr(4'h0, 16'h0000);
    wr(4'h0, 16'h0003);
    pulse(16'h0000);
    chk(16'(nDma - b0), 16'h0001);
    idleMode <= 1'b0;
    sleepMode <= 1'b1;
    pulse(16'h0000);
    chk(16'(nDma - b0), 16'h0001);
    // wake-up mode: rising edge interrupts during sleep
    wr(4'h0, 16'h0000);
    wr(4'h0, 16'h0007);
    irqEn <= 1'b1;
    b0 = nIrq;
    pulse(16'h0000);
    chk(16'(nIrq - b0), 16'h0001);
    close_out;
  end
  // roughly 1000 cycles of traffic expected; a hang is cut off far beyond that
  initial
  begin
    #200000;
    n_fail++;
    close_out;
  end
endmodule // input_capture_fifo_irq_tb
